// file: hw/mam_top.sv
/*
 * Modbus slave address mapper: four base registers place the coil,
 * discrete input, input register and holding register areas inside a
 * 16-bit word database. Software reaches everything over APB.
 * Assumes a single 10 MHz clock and a master obeying APB signalling.
 */
// The implementer's own choices: the register addresses and register access over APB.
// Behaviour
// - Discrete input 10001 lands in bit zero of the discrete input base word.
// - Input register 30001 lands in the input register base word, onward.
// - Coil 0001 lands in bit zero of the coil base word, onward.
// - Holding register 40001 lands in the holding base word, onward.
// - Sixteen consecutive bit addresses share one word, low bit first.
// - The discrete input base accepts only 0 to 3998.
// - Bases only move the start; areas may alias without any check.
// - The database holds 5000 words of 16 bits.
`timescale 1ns/100ps
`default_nettype none
`include "mam_defines.svh"

module mam_top
   import mam_pkg::*;
#(
   parameter int DB_WORDS = `MAM_DB_WORDS
)(
   input wire logic ref_clk_i,       // 10 MHz clock
   input wire logic reset_n_i,       // Async reset, active low
   input wire logic psel_i,          // APB select
   input wire logic penable_i,       // APB enable
   input wire logic pwrite_i,        // APB direction
   input wire logic [11:0] paddr_i,  // APB byte address
   input wire logic [31:0] pwdata_i, // APB write data
   output logic [31:0] prdata_o,     // APB read data
   output logic pready_o,            // APB ready
   output logic pslverr_o,           // APB error
   output logic [7:0] exc_code_o     // Last Modbus exception code
);
   // Database words
   logic [15:0] mem [DB_WORDS];

   // Base registers, in database words
   logic [`MAM_IDX_W-1:0] di_base, ir_base, co_base, hr_base;
   logic [`MAM_IDX_W-1:0] next_di_base, next_ir_base;
   logic [`MAM_IDX_W-1:0] next_co_base, next_hr_base;

   // Pending lookup and its result
   logic [15:0] req_addr, next_req_addr;
   mam_area_t req_area, next_req_area;
   logic [15:0] wdata, next_wdata;
   logic [15:0] rdata, next_rdata;
   logic exc, next_exc;
   logic [7:0] exc_code, next_exc_code;
   logic base_err, next_base_err;

   // Registered bus answer
   logic [31:0] prdata, next_prdata;
   logic pready, next_pready;
   logic pslverr, next_pslverr;

   // Lookup sequencer and database port
   mam_state_t state, next_state;
   logic [`MAM_IDX_W-1:0] widx, next_widx;
   logic [`MAM_IDX_W-1:0] db_idx;
   logic [15:0] db_word;
   logic mem_we;
   logic [15:0] mem_wval;

   logic setup, wr_acc, rd_acc;
   logic [15:0] new_word;

   // Translator link
   mam_xlat_if xif ();

   mam_xlat #(
      .DB_WORDS(DB_WORDS)
   ) u_xlat (
      .x(xif)
   );

   // Base selection by area
   always_comb
   begin
      xif.area = req_area;
      xif.addr = req_addr;
      case (req_area)
         MAM_COIL: xif.base = co_base;
         MAM_DISC: xif.base = di_base;
         MAM_INREG: xif.base = ir_base;
         MAM_HOLD: xif.base = hr_base;
         // Unreachable; all four areas decoded
         default: xif.base = hr_base;
      endcase
   end

   // Access taken at the first enable edge; pready blocks a repeat
   // APB phases; one wait state, answer on second access cycle
   assign setup = psel_i && !penable_i;
   assign wr_acc = psel_i && penable_i && pwrite_i && !pready;
   assign rd_acc = psel_i && penable_i && !pwrite_i && !pready;

   // Database port; outside the array reads zero, never an unknown
   assign db_idx = xif.word_idx;
   assign db_word = xif.in_range ? mem[db_idx] : 16'h0000;

   // merge one bit, low bit first
   always_comb
   begin
      new_word = db_word;
      new_word[xif.bit_idx] = wdata[0];
   end

   // Register, sequencer and bus next-state
   always_comb
   begin
      next_di_base = di_base;
      next_ir_base = ir_base;
      next_co_base = co_base;
      next_hr_base = hr_base;
      next_req_addr = req_addr;
      next_req_area = req_area;
      next_wdata = wdata;
      next_rdata = rdata;
      next_exc = exc;
      next_exc_code = exc_code;
      next_base_err = base_err;
      next_prdata = prdata;
      next_pready = 1'b0;
      next_pslverr = 1'b0;
      next_state = state;
      next_widx = widx;
      mem_we = 1'b0;
      mem_wval = 16'h0000;

      // Mapped access from a request launched earlier
      case (state)
         MAM_IDLE: next_state = MAM_IDLE;
         MAM_READ, MAM_WRITE:
         begin
            // Lookup takes one cycle and records its index
            next_state = MAM_IDLE;
            next_widx = db_idx;
            if (!xif.in_range)
            begin
               next_exc = 1'b1;
               next_exc_code = `MAM_EXC_ILLEGAL_ADDR;
            end
            else if (state == MAM_READ)
            begin
               next_exc = 1'b0;
               next_exc_code = 8'h00;
               // Bit areas answer with one bit
               if (req_area == MAM_COIL || req_area == MAM_DISC)
                  next_rdata = {15'h0000, db_word[xif.bit_idx]};
               else
                  next_rdata = db_word;
            end
            else
            begin
               next_exc = 1'b0;
               next_exc_code = 8'h00;
               mem_we = 1'b1;
               if (req_area == MAM_COIL || req_area == MAM_DISC)
                  mem_wval = new_word;
               else
                  mem_wval = wdata;
            end
         end
         default: next_state = MAM_IDLE;
      endcase

      if (setup)
         next_pready = 1'b0;
      else if (wr_acc)
      begin
         next_pready = 1'b1;
         case (paddr_i)
            `MAM_OFS_DI_BASE:
            begin
               if (pwdata_i[`MAM_IDX_W-1:0] > `MAM_DI_BASE_MAX
                   || |pwdata_i[31:`MAM_IDX_W])
               begin
                  next_pslverr = 1'b1;
                  next_base_err = 1'b1;
               end
               else
                  next_di_base = pwdata_i[`MAM_IDX_W-1:0];
            end
            `MAM_OFS_IR_BASE: next_ir_base = pwdata_i[`MAM_IDX_W-1:0];
            `MAM_OFS_CO_BASE: next_co_base = pwdata_i[`MAM_IDX_W-1:0];
            `MAM_OFS_HR_BASE: next_hr_base = pwdata_i[`MAM_IDX_W-1:0];
            // Bit areas take bit 0 of this word
            `MAM_OFS_WDATA: next_wdata = pwdata_i[15:0];
            // Writing one clears the base error
            `MAM_OFS_STATUS:
               if (pwdata_i[`MAM_ST_BERR_BIT])
                  next_base_err = 1'b0;
            `MAM_OFS_REQ:
            begin
               // A busy sequencer refuses a new request
               if (state != MAM_IDLE)
                  next_pslverr = 1'b1;
               else
               begin
                  next_req_addr = pwdata_i[`MAM_REQ_ADDR_LSB +: 16];
                  next_req_area = mam_area_t'(pwdata_i[`MAM_REQ_TYPE_LSB +: 2]);
                  next_state = pwdata_i[`MAM_REQ_WR_BIT] ? MAM_WRITE : MAM_READ;
               end
            end
            // Unmapped offsets are refused
            default: next_pslverr = 1'b1;
         endcase
      end
      else if (rd_acc)
      begin
         next_pready = 1'b1;
         case (paddr_i)
            `MAM_OFS_DI_BASE: next_prdata = {19'h00000, di_base};
            `MAM_OFS_IR_BASE: next_prdata = {19'h00000, ir_base};
            `MAM_OFS_CO_BASE: next_prdata = {19'h00000, co_base};
            `MAM_OFS_HR_BASE: next_prdata = {19'h00000, hr_base};
            // Request echoes a pending write lookup, area and offset
            `MAM_OFS_REQ:
               next_prdata = {13'h0000, state == MAM_WRITE, req_area,
                              req_addr};
            `MAM_OFS_WDATA: next_prdata = {16'h0000, wdata};
            // Status packs code, base error, exception, busy
            `MAM_OFS_STATUS:
               next_prdata = {21'h000000, exc_code, base_err, exc,
                              state != MAM_IDLE};
            `MAM_OFS_RDATA: next_prdata = {16'h0000, rdata};
            `MAM_OFS_WIDX: next_prdata = {19'h00000, widx};
            default:
            begin
               next_prdata = 32'h00000000;
               next_pslverr = 1'b1;
            end
         endcase
      end
   end

   // Flops for registers and bus answer
   always_ff @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         di_base <= `MAM_RST_DI_BASE;
         ir_base <= `MAM_RST_IR_BASE;
         co_base <= `MAM_RST_CO_BASE;
         hr_base <= `MAM_RST_HR_BASE;
         req_addr <= 16'h0000;
         req_area <= MAM_COIL;
         wdata <= 16'h0000;
         rdata <= 16'h0000;
         exc <= 1'b0;
         exc_code <= 8'h00;
         base_err <= 1'b0;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         state <= MAM_IDLE;
         widx <= '0;
      end
      else
      begin
         di_base <= next_di_base;
         ir_base <= next_ir_base;
         co_base <= next_co_base;
         hr_base <= next_hr_base;
         req_addr <= next_req_addr;
         req_area <= next_req_area;
         wdata <= next_wdata;
         rdata <= next_rdata;
         exc <= next_exc;
         exc_code <= next_exc_code;
         base_err <= next_base_err;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
         state <= next_state;
         widx <= next_widx;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (mem_we)
         mem[db_idx] <= mem_wval;
   end

   // Outputs come straight from flops
   assign prdata_o = prdata;
   assign pready_o = pready;
   assign pslverr_o = pslverr;
   assign exc_code_o = exc_code;
endmodule

`default_nettype wire

// file: inc/mam_defines.svh
/*
 * Constants of the slave address mapper: register offsets, field
 * positions, reset values and database sizes.
 * Assumes inclusion by bare name from package and design files.
 */
`ifndef MAM_DEFINES_SVH
`define MAM_DEFINES_SVH

// Database size in 16-bit words
`define MAM_DB_WORDS 5000
`define MAM_IDX_W 13
// Largest accepted discrete-input base
`define MAM_DI_BASE_MAX 13'h0F9E
// Register byte offsets
`define MAM_OFS_DI_BASE 12'h000
`define MAM_OFS_IR_BASE 12'h004
`define MAM_OFS_CO_BASE 12'h008
`define MAM_OFS_HR_BASE 12'h00C
`define MAM_OFS_REQ 12'h010
`define MAM_OFS_WDATA 12'h014
`define MAM_OFS_STATUS 12'h018
`define MAM_OFS_RDATA 12'h01C
`define MAM_OFS_WIDX 12'h020
// Request register fields
`define MAM_REQ_ADDR_LSB 0
`define MAM_REQ_TYPE_LSB 16
`define MAM_REQ_WR_BIT 18
// Status register fields
`define MAM_ST_BUSY_BIT 0
`define MAM_ST_EXC_BIT 1
`define MAM_ST_BERR_BIT 2
// Reset values of the bases
`define MAM_RST_DI_BASE 13'h0000
`define MAM_RST_IR_BASE 13'h000A
`define MAM_RST_CO_BASE 13'h03E8
`define MAM_RST_HR_BASE 13'h03F2
// Modbus exception code for an illegal data address
`define MAM_EXC_ILLEGAL_ADDR 8'h02

`endif

// file: inc/mam_pkg.sv
/*
 * Types of the slave address mapper.
 * Assumes mam_defines.svh is on the include path.
 */
`include "mam_defines.svh"

package mam_pkg;
   // Modbus data area of a request
   typedef enum logic [1:0] {
      MAM_COIL = 2'h0,
      MAM_DISC = 2'h1,
      MAM_INREG = 2'h2,
      MAM_HOLD = 2'h3
   } mam_area_t;

   // Request sequencer states, one bit apart from idle to either
   typedef enum logic [1:0] {
      MAM_IDLE = 2'h0,
      MAM_READ = 2'h1,
      MAM_WRITE = 2'h2
   } mam_state_t;
endpackage

// file: inc/mam_xlat_if.sv
/*
 * Interface between the sequencer and the address translator.
 * Assumes both ends run on one clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "mam_defines.svh"

interface mam_xlat_if;
   import mam_pkg::*;
   mam_area_t area;
   logic [15:0] addr;
   logic [`MAM_IDX_W-1:0] base;
   logic [`MAM_IDX_W-1:0] word_idx;
   logic [3:0] bit_idx;
   logic in_range;
   modport req (output area, addr, base, input word_idx, bit_idx, in_range);
   modport xlat (input area, addr, base, output word_idx, bit_idx, in_range);
endinterface

`default_nettype wire

// file: hw/mam_xlat.sv
/*
 * Combinational translator from a zero-based Modbus data address to a
 * database word index and bit position.
 * Assumes the address is already stripped of its area prefix.
 */
`timescale 1ns/100ps
`default_nettype none
`include "mam_defines.svh"

module mam_xlat
   import mam_pkg::*;
#(
   parameter int DB_WORDS = `MAM_DB_WORDS
)(
   mam_xlat_if.xlat x   // Translation request and result
);
   logic [16:0] sum;
   logic bit_area;

   // bit areas pack sixteen per word
   always_comb
   begin
      bit_area = (x.area == MAM_COIL) || (x.area == MAM_DISC);
      // base is a plain start point
      if (bit_area)
         sum = {5'h00, x.addr[15:4]} + {4'h0, x.base};
      else
         sum = {1'b0, x.addr} + {4'h0, x.base};
   end

   assign x.bit_idx = bit_area ? x.addr[3:0] : 4'h0;
   assign x.word_idx = sum[`MAM_IDX_W-1:0];
   assign x.in_range = (sum < 17'(DB_WORDS));
endmodule

`default_nettype wire

// file: dv/mam_top_checker.sv
/* Port checker for the address mapper.
   Assumes bind into mam_top, one clock. */
`timescale 1ns/100ps
`default_nettype none

module mam_top_checker
   import mam_pkg::*;
#(
   parameter int DB_WORDS = 5000
)(
   input wire logic ref_clk_i,       // Clock
   input wire logic reset_n_i,       // Reset, low
   input wire logic psel_i,          // Select
   input wire logic penable_i,       // Enable
   input wire logic pwrite_i,        // Direction
   input wire logic [11:0] paddr_i,  // Address
   input wire logic [31:0] pwdata_i, // Write data
   input wire logic [31:0] prdata_o, // Read data
   input wire logic pready_o,        // Ready
   input wire logic pslverr_o,       // Error
   input wire logic [7:0] exc_code_o // Exception
);
   default clocking @(posedge ref_clk_i);
   endclocking
   default disable iff (!reset_n_i);
   logic acc;
   logic dib;
   // Access phase waiting for its answer
   assign acc = psel_i && penable_i && !pready_o;
   assign dib = acc && pwrite_i && paddr_i == 12'h000;
   // Bus handshake, base range and exception code checks
   a_ready_wait: assert property (acc |=> pready_o)
      else $error("ready missing after access");
   a_ready_pulse: assert property (pready_o |=> !pready_o)
      else $error("ready held too long");
   a_setup_quiet: assert property (psel_i && !penable_i |=> !pready_o)
      else $error("ready in setup");
   a_err_pulse: assert property (pslverr_o |-> pready_o)
      else $error("error without ready");
   a_base_ok: assert property (
      dib && pwdata_i <= 32'hF9E |=> !pslverr_o)
      else $error("legal base refused");
   a_base_bad: assert property (
      dib && pwdata_i > 32'hF9E |=> pslverr_o)
      else $error("bad base accepted");
   a_exc_values: assert property (
      exc_code_o == 8'h00 || exc_code_o == 8'h02)
      else $error("odd exception code");
   a_exc_hold: assert property (
      $changed(exc_code_o) |-> $past(pready_o) || $past(pready_o, 2))
      else $error("exception moved alone");
endmodule

bind mam_top mam_top_checker #(.DB_WORDS(DB_WORDS)) u_chk (
   .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .exc_code_o(exc_code_o));

`default_nettype wire

// file: dv/mam_apb_mst.sv
/* APB master model issuing requests.
   Assumes calls start just after a rising edge. */
`timescale 1ns/100ps
`default_nettype none

module mam_apb_mst (
   input wire logic ref_clk_i,        // Clock
   input wire logic pready_i,         // Ready
   input wire logic pslverr_i,        // Error
   input wire logic [31:0] prdata_i,  // Read data
   output logic psel_o,               // Select
   output logic penable_o,            // Enable
   output logic pwrite_o,             // Direction
   output logic [11:0] paddr_o,       // Address
   output logic [31:0] pwdata_o       // Write data
);
   // Idle bus at time zero
   initial
   begin
      psel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = 1'b0;
      paddr_o = 12'h000;
      pwdata_o = 32'h0;
   end

   // One transfer, held until ready; idle lines show inverse
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
      psel_o <= 1'b1;
      pwrite_o <= w;
      paddr_o <= a;
      pwdata_o <= d;
      @(posedge ref_clk_i);
      penable_o <= 1'b1;
      @(posedge ref_clk_i);
      while (pready_i !== 1'b1)
         @(posedge ref_clk_i);
      q = prdata_i;
      e = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      paddr_o <= ~a;
      pwdata_o <= ~d;
      @(posedge ref_clk_i);
   endtask
endmodule

`default_nettype wire

// file: dv/mam_top_tb.sv
/* Testbench of the address mapper.
   Assumes the APB master model and checker. */
`timescale 1ns/100ps
`default_nettype none

module mam_top_tb;
   import mam_pkg::*;
   logic ref_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] exc_code;
   logic [15:0] ta [4] = '{16'h10, 16'h11, 16'h5, 16'hA};
   logic [31:0] te [4] = '{32'h3E9, 32'h1, 32'hF, 32'h3FC};
   int err_count = 0;
   int n_checks = 0;
   int cyc = 0;

   mam_top u_dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .exc_code_o(exc_code));
   mam_apb_mst u_mst (.ref_clk_i(ref_clk_i), .pready_i(pready),
      .pslverr_i(pslverr), .prdata_i(prdata), .psel_o(psel),
      .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
      .pwdata_o(pwdata));

   // Clock, 100 ns period
   always #50 ref_clk_i = ~ref_clk_i;

   task automatic stop_test;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      u_mst.xfer(1'b1, a, d, rd, err);
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      u_mst.xfer(1'b0, a, 32'h0, rd, err);
      chk(rd, e);
   endtask

   // Lookup: offset, area, write flag
   task automatic req(input logic [15:0] a, input logic [1:0] t,
      input logic w);
      wr(12'h010, {13'h0, w, t, a});
   endtask

   // Hang guard
   always @(posedge ref_clk_i)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         err_count++;
         stop_test;
      end
   end

   initial
   begin
      repeat (2) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      @(posedge ref_clk_i);
      rdc(12'h000, 32'h0);
      rdc(12'h004, 32'hA);
      rdc(12'h008, 32'h3E8);
      rdc(12'h00C, 32'h3F2);
      for (int i = 0; i < 4; i++)
      begin
         req(ta[i], 2'(i), 1'b0);
         rdc(12'h020, te[i]);
      end
      // coil 0161 and 40001 share a word
      wr(12'h014, 32'h1234);
      req(16'h0, 2'h3, 1'b1);
      wr(12'h014, 32'h1);
      req(16'hA0, 2'h0, 1'b1);
      rdc(12'h020, 32'h3F2);
      req(16'h0, 2'h3, 1'b0);
      rdc(12'h01C, 32'h1235);
      req(16'hA2, 2'h0, 1'b0);
      rdc(12'h01C, 32'h1);
      // discrete base limit, error flag clear
      wr(12'h000, 32'hF9E);
      chk({31'h0, err}, 32'h0);
      wr(12'h000, 32'hF9F);
      chk({31'h0, err}, 32'h1);
      rdc(12'h000, 32'hF9E);
      rdc(12'h018, 32'h4);
      wr(12'h018, 32'h4);
      rdc(12'h018, 32'h0);
      // discrete area aliased onto holding word
      wr(12'h000, 32'h3F2);
      req(16'h0, 2'h1, 1'b0);
      rdc(12'h01C, 32'h1);
      // last word and one past it
      req(16'hF96, 2'h3, 1'b0);
      rdc(12'h018, 32'h12);
      chk({24'h0, exc_code}, 32'h2);
      wr(12'h014, 32'h5A5A);
      req(16'hF95, 2'h3, 1'b1);
      req(16'hF95, 2'h3, 1'b0);
      rdc(12'h01C, 32'h5A5A);
      chk({24'h0, exc_code}, 32'h0);
      // Unmapped offset refused
      rdc(12'h030, 32'h0);
      chk({31'h0, err}, 32'h1);
      stop_test;
   end
endmodule

`default_nettype wire
